// ==== hdl/hbc_pkg.sv ====
// constants, field layouts and helper functions of the h-bridge current regulator
// assumes one 200 MHz clock and software access over an ahb-lite slave
// ------------------------------------------------------------------
// ------------------------------------------------------------------
package hbc_pkg;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_PS   = 5000;
	localparam int OFF_DEFAULT_NS  = 20000;
	localparam int OFF_MIN_NS      = 10000;
	localparam int OFF_MAX_NS      = 80000;
	localparam int OFF_PS_PER_KOHM = 667000;
	localparam int OFF_DEFAULT_CYC = OFF_DEFAULT_NS * 1000 / CLK_PERIOD_PS;
	localparam int OFF_MIN_CYC     = (OFF_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int OFF_MAX_CYC     = OFF_MAX_NS * 1000 / CLK_PERIOD_PS;
	localparam int TICK_NS         = 1000;
	localparam int TICK_CYC        = TICK_NS * 1000 / CLK_PERIOD_PS;
	localparam int RETRY_MS        = 3;
	localparam int RETRY_TICKS     = RETRY_MS * 1000000 / TICK_NS;
	localparam int BLANK_NS        = 1000;
	localparam int BLANK_CYC       = (BLANK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int FAST30_PCT      = 30;
	localparam int FAST60_PCT      = 60;
	localparam int TIME_W          = 16;

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	localparam logic [7:0]  CTRL_OFS   = 8'h00;
	localparam logic [7:0]  OFFT_OFS   = 8'h04;
	localparam logic [7:0]  STAT_OFS   = 8'h08;
	localparam int          CTRL_EN    = 0;
	localparam int          CTRL_AWAKE = 1;
	localparam int          CTRL_DEC   = 2;
	localparam int          CTRL_LVL   = 4;
	localparam int          OFFT_DEF   = 0;
	localparam int          OFFT_KOHM  = 8;
	localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
	localparam logic [31:0] OFFT_RST   = 32'h0000_0001;
	localparam int          STAT_OFF   = 0;
	localparam int          STAT_OCP   = 1;
	localparam int          STAT_THERM = 2;
	localparam int          STAT_UV    = 3;
	localparam int          STAT_FAULT = 4;
	localparam int          STAT_BR    = 8;

	typedef enum logic [1:0] {
		DEC_SLOW  = 2'h0,
		DEC_MIX30 = 2'h1,
		DEC_MIX60 = 2'h2,
		DEC_FAST  = 2'h3
	} hbc_decay_t;

	// trip level in tenths of a percent of full scale
	function automatic logic [9:0] hbc_trip_level(input logic [3:0] code);
		unique case (code)
			4'h0: hbc_trip_level = 10'd1000;
			4'h1: hbc_trip_level = 10'd992;
			4'h2: hbc_trip_level = 10'd976;
			4'h3: hbc_trip_level = 10'd953;
			4'h4: hbc_trip_level = 10'd913;
			4'h5: hbc_trip_level = 10'd866;
			4'h6: hbc_trip_level = 10'd811;
			4'h7: hbc_trip_level = 10'd740;
			4'h8: hbc_trip_level = 10'd669;
			4'h9: hbc_trip_level = 10'd591;
			4'hA: hbc_trip_level = 10'd504;
			4'hB: hbc_trip_level = 10'd409;
			4'hC: hbc_trip_level = 10'd307;
			4'hD: hbc_trip_level = 10'd205;
			4'hE: hbc_trip_level = 10'd102;
			4'hF: hbc_trip_level = 10'd0;
		endcase
	endfunction

	// raw off-time in clock cycles for a setting resistor in kohm
	function automatic int hbc_off_raw(input logic [7:0] kohm);
		hbc_off_raw = int'(kohm) * OFF_PS_PER_KOHM / CLK_PERIOD_PS;
	endfunction

endpackage

// ==== hdl/hbc_timer_if.sv ====
// link between the regulator and its off-time counter
// assumes both ends share hclk
interface hbc_timer_if;
	logic              start;
	logic [15:0]       len;
	logic [15:0]       elapsed;
	logic              running;
	modport ctrl  (output start, output len, input elapsed, input running);
	modport timer (input start, input len, output elapsed, output running);
endinterface

// ==== hdl/hbc_off_timer.sv ====
// fixed off-time counter; a start pulse (re)loads it at any time
// assumes len is stable while start is high
module hbc_off_timer (
	input  wire logic  hclk,
	input  wire logic  hresetn,
	hbc_timer_if.timer tif
);
	logic [15:0] cnt_q, cnt_d;
	logic        run_q, run_d;

	always_comb begin
		cnt_d = cnt_q;
		run_d = run_q;
		if (tif.start) begin
			cnt_d = 16'h0000;
			run_d = 1'b1;
		end else if (run_q) begin
			if (cnt_q == tif.len - 16'h0001)
				run_d = 1'b0;
			else
				cnt_d = cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 16'h0000;
			run_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			run_q <= run_d;
		end
	end

	assign tif.elapsed = cnt_q;
	assign tif.running = run_q;
endmodule // hbc_off_timer

// ==== hdl/hbc_ctrl.sv ====
// h-bridge control: chopper regulator, decay modes, protections, ahb-lite registers
// assumes comparator and sensor inputs already synchronous to hclk
module hbc_ctrl import hbc_pkg::*; #(
	parameter int OFF_MAX   = OFF_MAX_CYC,
	parameter int RETRY_TKS = RETRY_TICKS
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        pwm_in_a,
	input  wire logic        pwm_in_b,
	input  wire logic [9:0]  sense_level,
	input  wire logic        current_zero,
	input  wire logic        oc_detect,
	input  wire logic        temp_over,
	input  wire logic        temp_recovered,
	input  wire logic        supply_low,
	output logic             out_a_high,
	output logic             out_a_low,
	output logic             out_b_high,
	output logic             out_b_low,
	output logic             regulation_active_n_o,
	output logic             regulation_active_n_oe,
	output logic             fault_n_o,
	output logic             fault_n_oe
);
	typedef enum logic {REG_ON, REG_OFF} hbc_reg_st_t;
	typedef enum logic {PR_RUN, PR_HOLD} hbc_prot_st_t;

	hbc_timer_if tif ();
	hbc_off_timer u_timer (.hclk(hclk), .hresetn(hresetn), .tif(tif));

	// ------------------------------------------------------------------
	// ahb-lite slave, zero wait states
	// ------------------------------------------------------------------
	logic [31:0] ctrl_q, ctrl_d, offt_q, offt_d, rdata_d;
	logic        wr_q, wr_d;
	logic [7:0]  wa_q, wa_d;
	logic [31:0] status;
	logic        take;

	assign take = hsel && hready && htrans[1];

	always_comb begin
		wr_d   = take && hwrite;
		wa_d   = take ? haddr[7:0] : wa_q;
		ctrl_d = ctrl_q;
		offt_d = offt_q;
		if (wr_q && wa_q == CTRL_OFS)
			ctrl_d = {24'h0, hwdata[7:0]};
		if (wr_q && wa_q == OFFT_OFS)
			offt_d = {16'h0, hwdata[15:8], 7'h0, hwdata[0]};
		// next values are read so a read right after a write sees the new value
		rdata_d = 32'h0000_0000;
		if (take && !hwrite && haddr[31:8] == 24'h0) begin
			unique case (haddr[7:0])
				CTRL_OFS: rdata_d = ctrl_d;
				OFFT_OFS: rdata_d = offt_d;
				STAT_OFS: rdata_d = status;
				default:  rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// configuration decode
	// ------------------------------------------------------------------
	logic        en, awake, use_def, pwm_chg, drive, trip, bridge_ok;
	hbc_decay_t  decay;
	logic [3:0]  level;
	logic [15:0] off_len;
	int          raw;

	assign en      = ctrl_q[CTRL_EN];
	assign awake   = ctrl_q[CTRL_AWAKE];
	assign decay   = hbc_decay_t'(ctrl_q[CTRL_DEC +: 2]);
	assign level   = ctrl_q[CTRL_LVL +: 4];
	assign use_def = offt_q[OFFT_DEF];
	assign raw     = hbc_off_raw(offt_q[OFFT_KOHM +: 8]);

	always_comb begin
		if (use_def)
			off_len = 16'(OFF_DEFAULT_CYC);
		else if (raw < OFF_MIN_CYC)
			off_len = 16'(OFF_MIN_CYC);
		else if (raw > OFF_MAX)
			off_len = 16'(OFF_MAX);
		else
			off_len = 16'(raw);
	end

	// ------------------------------------------------------------------
	// protections
	// ------------------------------------------------------------------
	hbc_prot_st_t prot_q, prot_d;
	logic [15:0]  oc_cnt_q, oc_cnt_d;
	logic [23:0]  hold_q, hold_d;
	logic [7:0]   div_q, div_d;
	logic         therm_q, therm_d, fault_any, tick;

	assign tick = (div_q == 8'(TICK_CYC - 1));

	always_comb begin
		div_d    = tick ? 8'h00 : div_q + 8'h01;
		prot_d   = prot_q;
		hold_d   = hold_q;
		oc_cnt_d = oc_detect ? oc_cnt_q + 16'h0001 : 16'h0000;
		unique case (prot_q)
			PR_RUN: begin
				// blanking: a short spike shorter than the deglitch time is ignored
				if (oc_detect && oc_cnt_q == 16'(BLANK_CYC - 1)) begin
					prot_d   = PR_HOLD;
					hold_d   = 24'h000000;
				end
			end
			PR_HOLD: begin
				oc_cnt_d = 16'h0000;
				if (tick)
					hold_d = hold_q + 24'h000001;
				if (tick && hold_q == 24'(RETRY_TKS - 1))
					prot_d = PR_RUN;
			end
		endcase
		if (temp_over)
			therm_d = 1'b1;
		else if (temp_recovered)
			therm_d = 1'b0;
		else
			therm_d = therm_q;
		fault_any = (prot_d == PR_HOLD) || therm_d || supply_low;
	end

	// ------------------------------------------------------------------
	// current regulator and bridge drive
	// ------------------------------------------------------------------
	hbc_reg_st_t reg_q, reg_d;
	logic        pa_q, pb_q, start_q, start_d, dir_q, dir_d, zero_q, zero_d;
	logic        in_fast, fault_q, cdr_q;
	logic [15:0] len_q, len_d, fast_len;
	logic [3:0]  br_q, br_d;

	assign pwm_chg   = (pwm_in_a != pa_q) || (pwm_in_b != pb_q);
	assign drive     = pwm_in_a ^ pwm_in_b;
	assign bridge_ok = awake && en && !fault_any;
	assign trip      = drive && sense_level > hbc_trip_level(level);

	always_comb begin
		unique case (decay)
			DEC_SLOW:  fast_len = 16'h0000;
			DEC_MIX30: fast_len = 16'(32'(len_q) * FAST30_PCT / 100);
			DEC_MIX60: fast_len = 16'(32'(len_q) * FAST60_PCT / 100);
			DEC_FAST:  fast_len = len_q;
		endcase
		in_fast = reg_q == REG_OFF && !start_q && tif.elapsed < fast_len;
	end

	always_comb begin
		reg_d   = reg_q;
		start_d = 1'b0;
		dir_d   = dir_q;
		len_d   = len_q;
		zero_d  = zero_q || (in_fast && current_zero);
		if (!bridge_ok) begin
			reg_d = REG_ON;
		end else if (reg_q == REG_ON && trip) begin
			reg_d   = REG_OFF;
			start_d = 1'b1;
			dir_d   = pwm_in_a;
			len_d   = off_len;
			zero_d  = 1'b0;
		end else if (reg_q == REG_OFF && pwm_chg) begin
			start_d = 1'b1;
			len_d   = off_len;
		end else if (reg_q == REG_OFF && !start_q && !tif.running) begin
			reg_d = REG_ON;
		end
		// bridge order: {a_high, a_low, b_high, b_low}
		if (!bridge_ok)
			br_d = 4'h0;
		else if (reg_d == REG_OFF && in_fast)
			br_d = zero_d ? 4'h0 : (dir_q ? 4'h6 : 4'h9);
		else if (reg_d == REG_OFF)
			br_d = 4'h5;
		else
			br_d = {pwm_in_a, !pwm_in_a, pwm_in_b, !pwm_in_b};
	end

	assign tif.start = start_q;
	assign tif.len   = len_q;

	always_comb begin
		status = 32'h0000_0000;
		status[STAT_OFF]       = reg_q == REG_OFF;
		status[STAT_OCP]       = prot_q == PR_HOLD;
		status[STAT_THERM]     = therm_q;
		status[STAT_UV]        = supply_low;
		status[STAT_FAULT]     = fault_q;
		status[STAT_BR +: 4]   = br_q;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q  <= CTRL_RST;
			offt_q  <= OFFT_RST;
			wr_q    <= 1'b0;
			wa_q    <= 8'h00;
			hrdata  <= 32'h0000_0000;
			prot_q  <= PR_RUN;
			oc_cnt_q <= 16'h0000;
			hold_q  <= 24'h000000;
			div_q   <= 8'h00;
			therm_q <= 1'b0;
			reg_q   <= REG_ON;
			start_q <= 1'b0;
			dir_q   <= 1'b0;
			zero_q  <= 1'b0;
			len_q   <= 16'(OFF_DEFAULT_CYC);
			pa_q    <= 1'b0;
			pb_q    <= 1'b0;
			br_q    <= 4'h0;
			fault_q <= 1'b0;
			cdr_q   <= 1'b0;
		end else begin
			ctrl_q  <= ctrl_d;
			offt_q  <= offt_d;
			wr_q    <= wr_d;
			wa_q    <= wa_d;
			hrdata  <= rdata_d;
			prot_q  <= prot_d;
			oc_cnt_q <= oc_cnt_d;
			hold_q  <= hold_d;
			div_q   <= div_d;
			therm_q <= therm_d;
			reg_q   <= reg_d;
			start_q <= start_d;
			dir_q   <= dir_d;
			zero_q  <= zero_d;
			len_q   <= len_d;
			pa_q    <= pwm_in_a;
			pb_q    <= pwm_in_b;
			br_q    <= br_d;
			fault_q <= fault_any;
			cdr_q   <= reg_d == REG_OFF;
		end
	end

	// open-drain pins: level is always low, the enable carries the state
	assign hreadyout              = 1'b1;
	assign hresp                  = 1'b0;
	assign out_a_high             = br_q[3];
	assign out_a_low              = br_q[2];
	assign out_b_high             = br_q[1];
	assign out_b_low              = br_q[0];
	assign regulation_active_n_o  = 1'b0;
	assign regulation_active_n_oe = cdr_q;
	assign fault_n_o              = 1'b0;
	assign fault_n_oe             = fault_q;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	sequence s_oc_seen;
		prot_q == PR_RUN && oc_detect && oc_cnt_q == 16'(BLANK_CYC - 1);
	endsequence
	sequence s_hiz_fault;
		br_q == 4'h0 && fault_n_oe && prot_q == PR_HOLD;
	endsequence

	property p_trip;
		@(posedge hclk) disable iff (!hresetn)
		reg_q == REG_ON && bridge_ok && trip |=> reg_q == REG_OFF ##1 tif.running;
	endproperty
	a_trip: assert property (p_trip) else $error("trip did not start off phase");

	property p_cdr;
		@(posedge hclk) disable iff (!hresetn)
		regulation_active_n_oe == (reg_q == REG_OFF);
	endproperty
	a_cdr: assert property (p_cdr) else $error("monitor not tied to off phase");

	property p_default_len;
		@(posedge hclk) disable iff (!hresetn)
		start_q && $past(use_def) |-> len_q == 16'(OFF_DEFAULT_CYC);
	endproperty
	a_default_len: assert property (p_default_len) else $error("default off-time wrong");

	property p_len_range;
		@(posedge hclk) disable iff (!hresetn)
		start_q |-> len_q >= 16'(OFF_MIN_CYC) && 32'(len_q) <= OFF_MAX;
	endproperty
	a_len_range: assert property (p_len_range) else $error("off-time out of range");

	property p_restart;
		@(posedge hclk) disable iff (!hresetn)
		reg_q == REG_OFF && bridge_ok && pwm_chg |=> start_q ##1 tif.elapsed == 16'h0000;
	endproperty
	a_restart: assert property (p_restart) else $error("pwm edge did not restart");

	property p_oc;
		@(posedge hclk) disable iff (!hresetn)
		s_oc_seen |=> s_hiz_fault [*2];
	endproperty
	a_oc: assert property (p_oc) else $error("overcurrent not handled");

	property p_blank;
		@(posedge hclk) disable iff (!hresetn)
		$rose(prot_q == PR_HOLD) |-> $past(oc_detect) && $past(oc_detect, 2);
	endproperty
	a_blank: assert property (p_blank) else $error("overcurrent without deglitch");

	property p_therm;
		@(posedge hclk) disable iff (!hresetn)
		temp_over |=> fault_n_oe && br_q == 4'h0;
	endproperty
	a_therm: assert property (p_therm) else $error("thermal fault missed");

	property p_uv;
		@(posedge hclk) disable iff (!hresetn)
		supply_low |=> fault_n_oe && br_q == 4'h0;
	endproperty
	a_uv: assert property (p_uv) else $error("supply lockout missed");

	property p_disable;
		@(posedge hclk) disable iff (!hresetn)
		!en || !awake |=> br_q == 4'h0;
	endproperty
	a_disable: assert property (p_disable) else $error("bridge driven while off");

	property p_zero;
		@(posedge hclk) disable iff (!hresetn)
		bridge_ok && zero_q && in_fast && reg_d == REG_OFF |=> br_q == 4'h0;
	endproperty
	a_zero: assert property (p_zero) else $error("fast decay not released");
endmodule // hbc_ctrl

// ==== test/hbc_pwm_source.sv ====
// controller model: drives the two direction inputs of the bridge
// assumes the bench calls set_dir right after a rising edge of hclk
module hbc_pwm_source (
	input  wire logic hclk,
	output logic      pwm_in_a,
	output logic      pwm_in_b
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		pwm_in_a = 1'b0;
		pwm_in_b = 1'b0;
	end

	// pwm only on the direction inputs; enable is left to slow register writes
	task automatic set_dir(input logic [1:0] dir);
		pwm_in_a <= dir[1];
		pwm_in_b <= dir[0];
		@(posedge hclk);
	endtask
endmodule // hbc_pwm_source

// ==== test/hbc_ctrl_bench.sv ====
// bench of the h-bridge regulator: register bus, chopper, decay, protections
// assumes the controller model drives the direction inputs; retry shortened to 3 ticks
module hbc_ctrl_bench import hbc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        pwm_in_a, pwm_in_b, current_zero, oc_detect;
	logic        temp_over, temp_recovered, supply_low;
	logic [9:0]  sense_level;
	logic        out_a_high, out_a_low, out_b_high, out_b_low;
	logic        reg_oe, fault_oe, reg_o, fault_o;
	logic [3:0]  br;
	logic [31:0] r;
	int          num_errors, checks_done, c;
	int          thr[16] = '{1000, 992, 976, 953, 913, 866, 811, 740,
	                         669, 591, 504, 409, 307, 205, 102, 0};
	logic [7:0]  kohm[4] = '{8'h00, 8'h0A, 8'h1E, 8'h96};
	int          len[4]  = '{4000, 2000, 4002, 16000};

	assign hready = hreadyout;
	assign br     = {out_a_high, out_a_low, out_b_high, out_b_low};

	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	hbc_pwm_source i_pwm (.hclk(hclk), .pwm_in_a(pwm_in_a), .pwm_in_b(pwm_in_b));

	hbc_ctrl #(.RETRY_TKS(3)) i_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.pwm_in_a(pwm_in_a), .pwm_in_b(pwm_in_b), .sense_level(sense_level),
		.current_zero(current_zero), .oc_detect(oc_detect), .temp_over(temp_over),
		.temp_recovered(temp_recovered), .supply_low(supply_low),
		.out_a_high(out_a_high), .out_a_low(out_a_low), .out_b_high(out_b_high),
		.out_b_low(out_b_low), .regulation_active_n_o(reg_o),
		.regulation_active_n_oe(reg_oe), .fault_n_o(fault_o), .fault_n_oe(fault_oe)
	);

	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// hready is the slave's answer; a stuck bus ends the run
	task automatic rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 16);
		if (hready !== 1'b1) begin
			num_errors++;
			print_verdict();
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		hsize <= 3'h2;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		r = hrdata;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		check(r, exp);
	endtask

	// write lands on the edge that ends the data phase, outputs follow one edge later
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
		repeat (2) @(posedge hclk);
	endtask

	task automatic trip(input logic [9:0] s, input logic exp);
		sense_level <= s;
		repeat (2) @(posedge hclk);
		check(reg_oe, exp);
		sense_level <= 10'h000;
	endtask

	task automatic wait_off();
		c = 0;
		while (reg_oe === 1'b1) begin
			@(posedge hclk);
			c++;
			if (c > 20000) begin
				num_errors++;
				print_verdict();
			end
		end
	endtask

	// ------------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------------
	initial begin
		{hsel, hwrite, current_zero, oc_detect} = 4'h0;
		{temp_over, temp_recovered, supply_low} = 3'h0;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		htrans = 2'h0;
		hsize = 3'h2;
		sense_level = 10'h000;
		hresetn = 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rd(CTRL_OFS, CTRL_RST);
		rd(OFFT_OFS, OFFT_RST);
		rd(8'h0C, 32'h0000_0000);
		wr(8'h0C, 32'hFFFF_FFFF);
		rd(8'h0C, 32'h0000_0000);
		check(br, 4'h0);
		check({hresp, reg_o, fault_o}, 3'h0);
		// enable rises once and then stays high: it never carries pwm
		wr(CTRL_OFS, 32'h0000_0002);
		check(br, 4'h0);
		for (int i = 0; i < 4; i++) begin
			wr(CTRL_OFS, 32'h0000_0003);
			i_pwm.set_dir(i[1:0]);
			@(posedge hclk);
			check(br, 4'(32'h0000_A965 >> (4 * i)));
		end
		wr(CTRL_OFS, 32'h0000_0001);
		check(br, 4'h0);
		i_pwm.set_dir(2'h2);
		wr(OFFT_OFS, 32'h0000_0F00);
		for (int l = 0; l < 16; l++) begin
			wr(CTRL_OFS, (l << 4) | 3);
			trip(10'(thr[l]), 1'b0);
			trip(10'(thr[l] + 1), 1'b1);
			wait_off();
		end
		// off-time table: default pin setting, low clamp, formula, high clamp
		for (int k = 0; k < 4; k++) begin
			wr(OFFT_OFS, (k == 0) ? 32'h0000_0001 : {16'h0000, kohm[k], 8'h00});
			trip(10'h001, 1'b1);
			wait_off();
			check(c > len[k] - 4 && c < len[k] + 6, 1'b1);
		end
		wr(OFFT_OFS, 32'h0000_0F00);
		for (int d = 0; d < 4; d++) begin
			wr(CTRL_OFS, (d << 2) | 3);
			trip(10'd1001, 1'b1);
			// the fast portion starts once the off-time counter is loaded
			repeat (2) @(posedge hclk);
			check(br, (d == 0) ? 4'h5 : 4'h6);
			repeat (1000) @(posedge hclk);
			check(br, (d >= 2) ? 4'h6 : 4'h5);
			if (d == 3) begin
				current_zero <= 1'b1;
				repeat (2) @(posedge hclk);
				check(br, 4'h0);
				check(reg_oe, 1'b1);
				current_zero <= 1'b0;
			end
			wait_off();
			repeat (2) @(posedge hclk);
			check(br, 4'h9);
		end
		wr(CTRL_OFS, 32'h0000_0003);
		trip(10'd1001, 1'b1);
		repeat (1000) @(posedge hclk);
		rd(STAT_OFS, 32'h0000_0501);
		i_pwm.set_dir(2'h3);
		i_pwm.set_dir(2'h2);
		check(br, 4'h5);
		wait_off();
		check(c > 1990 && c < 2010, 1'b1);
		i_pwm.set_dir(2'h0);
		trip(10'd1001, 1'b0);
		check(br, 4'h5);
		i_pwm.set_dir(2'h2);
		// overcurrent held 150 cycles must be ignored, held 250 cycles it trips the hold-off
		oc_detect <= 1'b1;
		repeat (150) @(posedge hclk);
		check(fault_oe, 1'b0);
		repeat (100) @(posedge hclk);
		check(fault_oe, 1'b1);
		check(br, 4'h0);
		rd(STAT_OFS, 32'h0000_0012);
		oc_detect <= 1'b0;
		repeat (300) @(posedge hclk);
		check(fault_oe, 1'b1);
		repeat (500) @(posedge hclk);
		check(fault_oe, 1'b0);
		check(br, 4'h9);
		temp_over <= 1'b1;
		repeat (2) @(posedge hclk);
		check(fault_oe, 1'b1);
		check(br, 4'h0);
		rd(STAT_OFS, 32'h0000_0014);
		temp_over <= 1'b0;
		supply_low <= 1'b1;
		repeat (3) @(posedge hclk);
		check(fault_oe, 1'b1);
		temp_recovered <= 1'b1;
		repeat (3) @(posedge hclk);
		check(fault_oe, 1'b1);
		check(br, 4'h0);
		rd(STAT_OFS, 32'h0000_0018);
		temp_recovered <= 1'b0;
		supply_low <= 1'b0;
		repeat (3) @(posedge hclk);
		check(fault_oe, 1'b0);
		check(br, 4'h9);
		print_verdict();
	end
endmodule // hbc_ctrl_bench
